// [hdl/position_readout_consts.svh]
`ifndef POSITION_READOUT_CONSTS_SVH
`define POSITION_READOUT_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_LPF        8'h2A
`define IDX_OUTSRC     8'h2B
`define IDX_RXMAP      8'h2F
`define IDX_EXC_GAIN   8'h40
`define IDX_EXC_PER    8'h41
`define IDX_CRS_GAIN   8'h42
`define IDX_AMP_PER    8'h44
// writable bits of each register
`define MASK_LPF       16'h003C
`define MASK_OUTSRC    16'h0037
`define MASK_RXMAP     16'h0001
`define MASK_EXC_GAIN  16'h80FF
`define MASK_PER       16'hFFFF
`define MASK_CRS_GAIN  16'h803F
`define REG_RESET      16'h0000
// field positions
`define ANG_COEF_LSB   4
`define VEL_COEF_LSB   2
`define SRC_LSB        4
`define CAL_DIR_BIT    2
`define SKIP_ADC_BIT   1
`define SKIP_COIL_BIT  0
`define SWAP_BIT       0
`define OVR_BIT        15
// smallest filter coefficient and its shift
`define COEF_BASE      8'h10
`define COEF_SHIFT     4
// exciter base current in sixty-fourths
`define EXC_BASE_64THS 11'h0C0
`define CRS_GAIN_MAX   6'h16
// refresh unit time and clock period
`define UNIT_NS        2000
`define CLK_NS         50
`define UNIT_CYC       (`UNIT_NS / `CLK_NS)
`endif

// [hdl/position_readout_pkg.sv]
package position_readout_pkg;
    // wishbone request from master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [9:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;
    // wishbone answer to master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;
    // power-on startup sequence
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADC_CAL,
        ST_COIL_CHK,
        ST_DONE
    } startup_state_t;
endpackage

// [hdl/position_readout_ctrl.sv]
`timescale 1ns/1ps
`include "position_readout_consts.svh"
// Function
// - angle filter coefficient from bits 5:4, codes give 16/32/64/128
// - velocity filter coefficient from bits 3:2, codes give 16/32/64/128
// - low-pass filter digitized samples with the selected coefficients
// - angle source: 00/01 extrapolated, 10 filtered, 11 absolute
// - bit 2 picks clockwise or counter-clockwise increase during calibration
// - skip bit 1 omits ADC calibration from startup
// - skip bit 0 omits open-coil detection from startup
// - swap 1 routes pins 0-3 to fine, 4-7 coarse; 0 reverses
// - exciter override bit 15 forces gain code from bits 7:0
// - exciter gain refresh every period times 2 us
// - exciter period zero means the gain code never refreshes
// - exciter current is 2^exp times three plus fraction/64
// - coarse override bit 15 forces code 5:0, meaningful 0 to 22
// - amplifier gains refresh every amp period times 2 us, zero stops
module position_readout_ctrl (
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    input  wire logic                          ce_in,
    input  wire position_readout_pkg::wb_req_t wb_req_in,
    output      position_readout_pkg::wb_rsp_t wb_rsp_out,
    input  wire logic                          sample_valid_in,
    input  wire logic [15:0]                   angle_sample_in,
    input  wire logic [15:0]                   vel_sample_in,
    input  wire logic [15:0]                   extrap_angle_in,
    input  wire logic [15:0]                   abs_angle_in,
    input  wire logic [7:0]                    rx_pins_in,
    input  wire logic                          start_in,
    input  wire logic                          adc_cal_done_in,
    input  wire logic                          coil_check_done_in,
    input  wire logic [7:0]                    auto_exc_gain_in,
    input  wire logic [5:0]                    auto_coarse_gain_in,
    input  wire logic [5:0]                    auto_fine_gain_in,
    output      logic [7:0]                    angle_coef_out,
    output      logic [7:0]                    vel_coef_out,
    output      logic [15:0]                   angle_out,
    output      logic [15:0]                   velocity_out,
    output      logic                          cal_ccw_out,
    output      logic                          adc_cal_start_out,
    output      logic                          coil_check_start_out,
    output      logic                          startup_done_out,
    output      logic [3:0]                    fine_rx_out,
    output      logic [3:0]                    coarse_rx_out,
    output      logic [7:0]                    exc_gain_code_out,
    output      logic [10:0]                   exc_current_out,
    output      logic [5:0]                    coarse_gain_out,
    output      logic [5:0]                    fine_gain_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic [15:0] lpf_q;
    logic [15:0] outsrc_q;
    logic [15:0] rxmap_q;
    logic [15:0] exc_gain_q;
    logic [15:0] exc_per_q;
    logic [15:0] crs_gain_q;
    logic [15:0] amp_per_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic        wr_en;
    logic [7:0]  widx;
    logic [7:0]  rx_s1_q;
    logic [7:0]  rx_s2_q;
    logic [15:0] ang_flt_q;
    logic [15:0] vel_flt_q;
    logic [1:0]  ang_code;
    logic [1:0]  vel_code;
    logic [1:0]  src_sel;
    logic        exc_ovr;
    logic        crs_ovr;
    logic [15:0] per_arr [2];
    logic [5:0]  pre_q   [2];
    logic [15:0] cnt_q   [2];
    logic        tick    [2];
    position_readout_pkg::startup_state_t st_q;

    assign widx    = wb_req_in.adr[9:2];
    assign wr_en   = wb_req_in.cyc & wb_req_in.stb & wb_req_in.we & ~ack_q;
    assign ang_code = lpf_q[`ANG_COEF_LSB +: 2];
    assign vel_code = lpf_q[`VEL_COEF_LSB +: 2];
    assign src_sel = outsrc_q[`SRC_LSB +: 2];
    assign exc_ovr = exc_gain_q[`OVR_BIT];
    assign crs_ovr = crs_gain_q[`OVR_BIT];
    assign per_arr[0] = exc_per_q;
    assign per_arr[1] = amp_per_q;

    // byte-lane merge that keeps reserved bits at zero
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel,
                                          input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (sel[0]) v[7:0]  = dat[7:0];
        if (sel[1]) v[15:8] = dat[15:8];
        return v & mask;
    endfunction

    // one first-order low-pass step, y += (x - y) / 2^(4+code)
    function automatic logic [15:0] lpf_step(input logic [15:0] y,
                                             input logic [15:0] x,
                                             input logic [1:0]  code);
        logic signed [16:0] diff;
        logic [2:0]         sh;
        diff = $signed({x[15], x}) - $signed({y[15], y});
        sh   = 3'(`COEF_SHIFT) + {1'b0, code};
        diff = diff >>> sh;
        return y + diff[15:0];
    endfunction

    // register writes with byte enables
    // reserved bits masked
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lpf_q      <= `REG_RESET;
            outsrc_q   <= `REG_RESET;
            rxmap_q    <= `REG_RESET;
            exc_gain_q <= `REG_RESET;
            exc_per_q  <= `REG_RESET;
            crs_gain_q <= `REG_RESET;
            amp_per_q  <= `REG_RESET;
        end else if (ce_in && wr_en) begin
            unique case (widx)
                `IDX_LPF: lpf_q <=
                    merge(lpf_q, wb_req_in.dat, wb_req_in.sel, `MASK_LPF);
                `IDX_OUTSRC: outsrc_q <= merge(outsrc_q, wb_req_in.dat,
                    wb_req_in.sel, `MASK_OUTSRC);
                `IDX_RXMAP: rxmap_q <= merge(rxmap_q, wb_req_in.dat,
                    wb_req_in.sel, `MASK_RXMAP);
                `IDX_EXC_GAIN: exc_gain_q <= merge(exc_gain_q,
                    wb_req_in.dat, wb_req_in.sel, `MASK_EXC_GAIN);
                `IDX_EXC_PER: exc_per_q <= merge(exc_per_q, wb_req_in.dat,
                    wb_req_in.sel, `MASK_PER);
                `IDX_CRS_GAIN: crs_gain_q <= merge(crs_gain_q,
                    wb_req_in.dat, wb_req_in.sel, `MASK_CRS_GAIN);
                `IDX_AMP_PER: amp_per_q <= merge(amp_per_q, wb_req_in.dat,
                    wb_req_in.sel, `MASK_PER);
                default: ;
            endcase
        end
    end

    // read mux, unmapped words read zero
    always_comb begin
        rdat_d = 32'h0000_0000;
        unique case (widx)
            `IDX_LPF:      rdat_d[15:0] = lpf_q;
            `IDX_OUTSRC:   rdat_d[15:0] = outsrc_q;
            `IDX_RXMAP:    rdat_d[15:0] = rxmap_q;
            `IDX_EXC_GAIN: rdat_d[15:0] = exc_gain_q;
            `IDX_EXC_PER:  rdat_d[15:0] = exc_per_q;
            `IDX_CRS_GAIN: rdat_d[15:0] = crs_gain_q;
            `IDX_AMP_PER:  rdat_d[15:0] = amp_per_q;
            default:       rdat_d = 32'h0000_0000;
        endcase
    end

    // one-wait-state ack, dropped the cycle after
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else if (ce_in) begin
            ack_q  <= wb_req_in.cyc & wb_req_in.stb & ~ack_q;
            rdat_q <= rdat_d;
        end
    end
    assign wb_rsp_out.ack = ack_q;
    assign wb_rsp_out.dat = rdat_q;

    a_ack_single: assert property (ack_q && ce_in |=> !ack_q)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (
        ce_in && wb_req_in.cyc && wb_req_in.stb && !ack_q |=> ack_q)
        else $error("request not answered in one cycle");

    // coefficient values for the filters
    // angle coef map
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            angle_coef_out <= `COEF_BASE;
            vel_coef_out   <= `COEF_BASE;
        end else if (ce_in) begin
            angle_coef_out <= `COEF_BASE << ang_code;
            vel_coef_out   <= `COEF_BASE << vel_code;
        end
    end

    a_coef_map: assert property (
        ce_in |=> angle_coef_out == (`COEF_BASE << $past(ang_code)))
        else $error("angle coefficient does not match code");

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ang_flt_q <= 16'h0000;
            vel_flt_q <= 16'h0000;
        end else if (ce_in && sample_valid_in) begin
            ang_flt_q <= lpf_step(ang_flt_q, angle_sample_in, ang_code);
            vel_flt_q <= lpf_step(vel_flt_q, vel_sample_in, vel_code);
        end
    end

    // output angle selection and filtered velocity
    // angle source mux
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            angle_out    <= 16'h0000;
            velocity_out <= 16'h0000;
        end else if (ce_in) begin
            velocity_out <= vel_flt_q;
            unique case (src_sel)
                2'h2:    angle_out <= ang_flt_q;
                2'h3:    angle_out <= abs_angle_in;
                default: angle_out <= extrap_angle_in;
            endcase
        end
    end

    a_src_abs: assert property (
        ce_in && src_sel == 2'h3 |=> angle_out == $past(abs_angle_in))
        else $error("absolute angle not selected");

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cal_ccw_out <= 1'b0;
        end else if (ce_in) begin
            cal_ccw_out <= outsrc_q[`CAL_DIR_BIT];
        end
    end

    // power-on startup sequence with optional steps
    // adc cal skip
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q                 <= position_readout_pkg::ST_IDLE;
            adc_cal_start_out    <= 1'b0;
            coil_check_start_out <= 1'b0;
            startup_done_out     <= 1'b0;
        end else if (ce_in) begin
            adc_cal_start_out    <= 1'b0;
            coil_check_start_out <= 1'b0;
            unique case (st_q)
                position_readout_pkg::ST_IDLE: begin
                    if (start_in) begin
                        startup_done_out <= 1'b0;
                        if (!outsrc_q[`SKIP_ADC_BIT]) begin
                            st_q <= position_readout_pkg::ST_ADC_CAL;
                            adc_cal_start_out <= 1'b1;
                        end else if (!outsrc_q[`SKIP_COIL_BIT]) begin
                            st_q <= position_readout_pkg::ST_COIL_CHK;
                            coil_check_start_out <= 1'b1;
                        end else begin
                            st_q <= position_readout_pkg::ST_DONE;
                        end
                    end
                end
                position_readout_pkg::ST_ADC_CAL: begin
                    if (adc_cal_done_in) begin
                        if (!outsrc_q[`SKIP_COIL_BIT]) begin
                            st_q <= position_readout_pkg::ST_COIL_CHK;
                            coil_check_start_out <= 1'b1;
                        end else begin
                            st_q <= position_readout_pkg::ST_DONE;
                        end
                    end
                end
                position_readout_pkg::ST_COIL_CHK: begin
                    if (coil_check_done_in) begin
                        st_q <= position_readout_pkg::ST_DONE;
                    end
                end
                position_readout_pkg::ST_DONE: begin
                    startup_done_out <= 1'b1;
                    st_q             <= position_readout_pkg::ST_IDLE;
                end
            endcase
        end
    end

    a_skip_adc: assert property (
        ce_in && st_q == position_readout_pkg::ST_IDLE && start_in
        && outsrc_q[`SKIP_ADC_BIT] |=> !adc_cal_start_out)
        else $error("adc calibration started while skipped");

    // receiver pins, two-stage synchroniser then group routing
    // group swap
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_s1_q       <= 8'h00;
            rx_s2_q       <= 8'h00;
            fine_rx_out   <= 4'h0;
            coarse_rx_out <= 4'h0;
        end else if (ce_in) begin
            rx_s1_q <= rx_pins_in;
            rx_s2_q <= rx_s1_q;
            if (rxmap_q[`SWAP_BIT]) begin
                fine_rx_out   <= rx_s2_q[3:0];
                coarse_rx_out <= rx_s2_q[7:4];
            end else begin
                fine_rx_out   <= rx_s2_q[7:4];
                coarse_rx_out <= rx_s2_q[3:0];
            end
        end
    end

    a_swap_map: assert property (
        ce_in && rxmap_q[`SWAP_BIT] |=> fine_rx_out == $past(rx_s2_q[3:0]))
        else $error("fine group not on pins 0 to 3");

    // refresh timers: 0 exciter, 1 amplifiers
    // exciter refresh period
    for (genvar g = 0; g < 2; g++) begin : g_timer
        assign tick[g] = (per_arr[g] != 16'h0000)
                       && (pre_q[g] == 6'(`UNIT_CYC - 1))
                       && (cnt_q[g] == per_arr[g] - 16'h0001);
        always_ff @(posedge clk_in) begin
            if (rst_in || per_arr[g] == 16'h0000) begin
                pre_q[g] <= 6'h00;
                cnt_q[g] <= 16'h0000;
            end else if (ce_in) begin
                if (pre_q[g] == 6'(`UNIT_CYC - 1)) begin
                    pre_q[g] <= 6'h00;
                    cnt_q[g] <= tick[g] ? 16'h0000 : cnt_q[g] + 16'h0001;
                end else begin
                    pre_q[g] <= pre_q[g] + 6'h01;
                end
            end
        end
    end

    a_zero_period: assert property (exc_per_q == 16'h0000 |-> !tick[0])
        else $error("exciter refresh with zero period");
    a_tick_spacing: assert property (
        tick[0] && ce_in |=> !tick[0] [*8])
        else $error("exciter refresh ticks too close");

    // exciter gain code, override or periodic auto capture
    // exciter override
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            exc_gain_code_out <= 8'h00;
        end else if (ce_in) begin
            if (exc_ovr) begin
                exc_gain_code_out <= exc_gain_q[7:0];
            end else if (tick[0]) begin
                exc_gain_code_out <= auto_exc_gain_in;
            end
        end
    end

    a_exc_override: assert property (
        ce_in && exc_ovr |=> exc_gain_code_out == $past(exc_gain_q[7:0]))
        else $error("exciter override code not applied");
    a_exc_hold: assert property (
        ce_in && !exc_ovr && exc_per_q == 16'h0000
        |=> $stable(exc_gain_code_out))
        else $error("exciter code changed with zero period");

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            exc_current_out <= 11'h000;
        end else if (ce_in) begin
            exc_current_out <= (`EXC_BASE_64THS
                + {5'h00, exc_gain_code_out[5:0]})
                << exc_gain_code_out[7:6];
        end
    end

    // amplifier gain codes, coarse may be overridden
    // coarse override
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            coarse_gain_out <= 6'h00;
            fine_gain_out   <= 6'h00;
        end else if (ce_in) begin
            if (crs_ovr) begin
                coarse_gain_out <= (crs_gain_q[5:0] > `CRS_GAIN_MAX)
                                 ? `CRS_GAIN_MAX : crs_gain_q[5:0];
            end else if (tick[1]) begin
                coarse_gain_out <= auto_coarse_gain_in;
            end
            if (tick[1]) begin
                fine_gain_out <= auto_fine_gain_in;
            end
        end
    end

    a_coarse_ovr: assert property (
        ce_in && crs_ovr && crs_gain_q[5:0] <= `CRS_GAIN_MAX
        |=> coarse_gain_out == $past(crs_gain_q[5:0]))
        else $error("coarse override code not applied");
endmodule // position_readout_ctrl

// [tb/position_readout_ctrl_tb_top.sv]
`timescale 1ns/1ps
`include "position_readout_consts.svh"
module position_readout_ctrl_tb_top;
    logic                          clk_in;
    logic                          rst_in;
    logic                          ce_in;
    logic                          sample_valid_in;
    logic                          start_in;
    logic                          adc_cal_done_in;
    logic                          coil_check_done_in;
    logic [15:0]                   angle_sample_in;
    logic [15:0]                   vel_sample_in;
    logic [15:0]                   extrap_angle_in;
    logic [15:0]                   abs_angle_in;
    logic [7:0]                    rx_pins_in;
    logic [7:0]                    auto_exc_gain_in;
    logic [5:0]                    auto_coarse_gain_in;
    logic [5:0]                    auto_fine_gain_in;
    logic [7:0]                    angle_coef_out;
    logic [7:0]                    vel_coef_out;
    logic [15:0]                   angle_out;
    logic [15:0]                   velocity_out;
    logic                          cal_ccw_out;
    logic                          adc_cal_start_out;
    logic                          coil_check_start_out;
    logic                          startup_done_out;
    logic [3:0]                    fine_rx_out;
    logic [3:0]                    coarse_rx_out;
    logic [7:0]                    exc_gain_code_out;
    logic [10:0]                   exc_current_out;
    logic [5:0]                    coarse_gain_out;
    logic [5:0]                    fine_gain_out;
    position_readout_pkg::wb_req_t wb_req;
    position_readout_pkg::wb_rsp_t wb_rsp;
    int                            err_count;
    int                            n_tests;

    // device under test, every port driven or watched
    position_readout_ctrl u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .wb_req_in(wb_req), .wb_rsp_out(wb_rsp),
        .sample_valid_in(sample_valid_in), .angle_sample_in(angle_sample_in),
        .vel_sample_in(vel_sample_in), .extrap_angle_in(extrap_angle_in),
        .abs_angle_in(abs_angle_in), .rx_pins_in(rx_pins_in),
        .start_in(start_in), .adc_cal_done_in(adc_cal_done_in),
        .coil_check_done_in(coil_check_done_in),
        .auto_exc_gain_in(auto_exc_gain_in),
        .auto_coarse_gain_in(auto_coarse_gain_in),
        .auto_fine_gain_in(auto_fine_gain_in),
        .angle_coef_out(angle_coef_out), .vel_coef_out(vel_coef_out),
        .angle_out(angle_out), .velocity_out(velocity_out),
        .cal_ccw_out(cal_ccw_out), .adc_cal_start_out(adc_cal_start_out),
        .coil_check_start_out(coil_check_start_out),
        .startup_done_out(startup_done_out), .fine_rx_out(fine_rx_out),
        .coarse_rx_out(coarse_rx_out), .exc_gain_code_out(exc_gain_code_out),
        .exc_current_out(exc_current_out), .coarse_gain_out(coarse_gain_out),
        .fine_gain_out(fine_gain_out)
    );

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] idx,
                           input logic [15:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_in);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                    sel: 4'h3, dat: {16'h0000, wd}};
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        rd = wb_rsp.dat;
        wb_req <= '0;
        if (n >= 50) check(32'h0, 32'h1);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] x;
        wb_xfer(1'b1, idx, d, x);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        wb_xfer(1'b0, idx, 16'h0000, x);
        check(x, exp);
    endtask

    // reset values of outputs and registers, plus an unmapped index
    task automatic t_reset();
        check(32'(angle_coef_out), 32'h10);
        check(32'(vel_coef_out), 32'h10);
        check(32'(angle_out), 32'h1234);
        rdc(`IDX_LPF, 32'h0);
        rdc(`IDX_OUTSRC, 32'h0);
        rdc(`IDX_RXMAP, 32'h0);
        rdc(`IDX_EXC_GAIN, 32'h0);
        rdc(`IDX_EXC_PER, 32'h0);
        rdc(`IDX_CRS_GAIN, 32'h0);
        rdc(`IDX_AMP_PER, 32'h0);
        rdc(8'h30, 32'h0);
    endtask

    // every coefficient code, reserved bits written as ones
    task automatic t_coef();
        for (int c = 0; c < 4; c++) begin
            wr(`IDX_LPF, 16'(16'hFFC3 | (c * 20)));
            rdc(`IDX_LPF, 32'(c * 20));
            cyc(2);
            check(32'(angle_coef_out), 32'h10 << c);
            check(32'(vel_coef_out), 32'h10 << c);
        end
    endtask

    // every source code and both rotation senses
    task automatic t_src();
        logic [31:0] exp;
        for (int s = 0; s < 4; s++) begin
            wr(`IDX_OUTSRC, 16'(16'hFFC8 | (s * 16) | ((s % 2) * 4)));
            rdc(`IDX_OUTSRC, 32'((s * 16) | ((s % 2) * 4)));
            cyc(3);
            exp = (s < 2) ? 32'h1234 : (s == 2) ? 32'h0 : 32'h5678;
            check(32'(angle_out), exp);
            check(32'(cal_ccw_out), 32'(s % 2));
        end
    endtask

    // one filter step with distinct angle and velocity coefficients
    task automatic t_filter();
        wr(`IDX_LPF, 16'h0018);
        wr(`IDX_OUTSRC, 16'h0020);
        @(posedge clk_in);
        angle_sample_in <= 16'h0400;
        vel_sample_in <= 16'h0400;
        sample_valid_in <= 1'b1;
        @(posedge clk_in);
        sample_valid_in <= 1'b0;
        cyc(3);
        check(32'(angle_out), 32'h20);
        check(32'(velocity_out), 32'h10);
    endtask

    // both receiver group mappings, then a frozen clock enable
    task automatic t_rx();
        for (int b = 0; b < 2; b++) begin
            wr(`IDX_RXMAP, 16'(16'hFFFE | b));
            rdc(`IDX_RXMAP, 32'(b));
            cyc(4);
            check(32'(fine_rx_out), b ? 32'h5 : 32'hA);
            check(32'(coarse_rx_out), b ? 32'hA : 32'h5);
        end
        ce_in <= 1'b0;
        rx_pins_in <= 8'h3C;
        cyc(5);
        check(32'(fine_rx_out), 32'h5);
        ce_in <= 1'b1;
        cyc(4);
        check(32'(fine_rx_out), 32'hC);
        check(32'(coarse_rx_out), 32'h3);
    endtask

    // exciter override, idle period and refresh timing
    task automatic t_exc();
        auto_exc_gain_in <= 8'h33;
        wr(`IDX_EXC_GAIN, 16'hFFC5);
        rdc(`IDX_EXC_GAIN, 32'h80C5);
        cyc(3);
        check(32'(exc_gain_code_out), 32'hC5);
        check(32'(exc_current_out), 32'h628);
        wr(`IDX_EXC_PER, 16'h0002);
        cyc(100);
        check(32'(exc_gain_code_out), 32'hC5);
        wr(`IDX_EXC_PER, 16'h0000);
        wr(`IDX_EXC_GAIN, 16'h00C5);
        cyc(200);
        check(32'(exc_gain_code_out), 32'hC5);
        wr(`IDX_EXC_PER, 16'h0002);
        cyc(70);
        check(32'(exc_gain_code_out), 32'hC5);
        cyc(20);
        check(32'(exc_gain_code_out), 32'h33);
        cyc(2);
        check(32'(exc_current_out), 32'h0F3);
    endtask

    // coarse override, saturation and amplifier refresh
    task automatic t_coarse();
        auto_coarse_gain_in <= 6'h07;
        auto_fine_gain_in <= 6'h09;
        wr(`IDX_CRS_GAIN, 16'hFF90);
        rdc(`IDX_CRS_GAIN, 32'h8010);
        cyc(2);
        check(32'(coarse_gain_out), 32'h10);
        wr(`IDX_CRS_GAIN, 16'h803F);
        wr(`IDX_AMP_PER, 16'h0001);
        cyc(50);
        check(32'(coarse_gain_out), 32'h16);
        check(32'(fine_gain_out), 32'h09);
        wr(`IDX_CRS_GAIN, 16'h0000);
        cyc(50);
        check(32'(coarse_gain_out), 32'h07);
        wr(`IDX_AMP_PER, 16'h0000);
        auto_coarse_gain_in <= 6'h0C;
        cyc(100);
        check(32'(coarse_gain_out), 32'h07);
    endtask

    // startup after a fresh reset, with the given skip bits
    task automatic t_start(input logic [1:0] skip);
        logic a;
        logic c;
        a = 1'b0;
        c = 1'b0;
        @(posedge clk_in);
        rst_in <= 1'b1;
        cyc(2);
        rst_in <= 1'b0;
        wr(`IDX_OUTSRC, 16'(skip));
        @(posedge clk_in);
        start_in <= 1'b1;
        @(posedge clk_in);
        start_in <= 1'b0;
        repeat (30) begin
            @(posedge clk_in);
            adc_cal_done_in <= adc_cal_start_out;
            coil_check_done_in <= coil_check_start_out;
            a = a | adc_cal_start_out;
            c = c | coil_check_start_out;
        end
        check(32'({a, c}), 32'(skip ^ 2'b11));
        check(32'(startup_done_out), 32'h1);
    endtask

    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // free-running clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // watchdog well beyond the expected run
    initial begin
        cyc(20000);
        err_count++;
        conclude();
    end

    // main sequence
    initial begin
        err_count = 0;
        n_tests = 0;
        rst_in = 1'b1;
        ce_in = 1'b1;
        wb_req = '0;
        sample_valid_in = 1'b0;
        start_in = 1'b0;
        adc_cal_done_in = 1'b0;
        coil_check_done_in = 1'b0;
        angle_sample_in = 16'h0000;
        vel_sample_in = 16'h0000;
        extrap_angle_in = 16'h1234;
        abs_angle_in = 16'h5678;
        rx_pins_in = 8'hA5;
        auto_exc_gain_in = 8'h00;
        auto_coarse_gain_in = 6'h00;
        auto_fine_gain_in = 6'h00;
        cyc(8);
        rst_in <= 1'b0;
        cyc(2);
        t_reset();
        t_coef();
        t_src();
        t_filter();
        t_rx();
        t_exc();
        t_coarse();
        for (int k = 0; k < 4; k++) t_start(2'(k));
        conclude();
    end
endmodule // position_readout_ctrl_tb_top
